// [hw/serial_register_access_slave.sv]
// Device-side serial register access port: two-wire slave and SPI slave
// sharing the clock and data pins, plus the write FIFO toward the registers.
// Assumes pins are asynchronous to i_clk and the register side is on i_clk.
`timescale 1ns/1ps
`include "sra_defs.svh"

module sra_fifo #(
  parameter int WIDTH = `SRA_FIFO_WIDTH,
  parameter int DEPTH = `SRA_FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push;
  logic             pop;

  // Count is one bit wider than the pointers so full and empty differ
  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    cnt_next    = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
  end

  // Storage needs no reset; valid words are tracked by the count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule // sra_fifo

module serial_register_access_slave (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_cs_b,
  input  wire logic               i_scl_sclk,
  input  wire logic               i_sda_sdi,
  output logic                    o_sda_o,
  output logic                    o_sda_oe_b,
  output logic                    o_sdo,
  output logic                    o_sdo_oe_b,
  input  wire logic               i_address_select_pin,
  input  wire logic               i_two_wire_port_disable,
  output sra_pkg::reg_index_t     o_rd_index,
  input  wire sra_pkg::data_byte_t i_rd_data,
  output logic                    o_rd_strobe,
  output logic                    o_wr_valid,
  input  wire logic               i_wr_ready,
  output sra_pkg::reg_index_t     o_wr_index,
  output sra_pkg::data_byte_t     o_wr_data
);
  import sra_pkg::*;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic       cs_s, scl_s, sda_s, addr_s;
  logic       cs_fall, scl_rise, scl_fall, start_c, stop_c;
  // Pins idle high, so a high reset value avoids a false edge on release
  localparam logic [3:0] SYNC_RST = `SRA_SYNC_RST;

  assign pin_raw = {i_address_select_pin, i_sda_sdi, i_scl_sclk, i_cs_b};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          sync1_reg[g] <= SYNC_RST[g];
          sync2_reg[g] <= SYNC_RST[g];
          prev_reg[g]  <= SYNC_RST[g];
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g]  <= sync2_reg[g];
        end
      end
    end
  endgenerate

  assign cs_s     = sync2_reg[0];
  assign scl_s    = sync2_reg[1];
  assign sda_s    = sync2_reg[2];
  assign addr_s   = sync2_reg[3];
  assign cs_fall  = prev_reg[0] && !cs_s;
  assign scl_rise = !prev_reg[1] && scl_s;
  assign scl_fall = prev_reg[1] && !scl_s;
  // Clock line high through the edge; data edge marks the condition
  assign start_c  = scl_s && prev_reg[1] && prev_reg[2] && !sda_s;
  assign stop_c   = scl_s && prev_reg[1] && !prev_reg[2] && sda_s;

  // --------------------------------------------------------------------
  // Protocol engine
  // --------------------------------------------------------------------
  tw_state_e  st_reg, st_next;
  tw_state_e  after_reg, after_next;
  logic [2:0] bit_reg, bit_next;
  data_byte_t rx_reg, rx_next;
  data_byte_t tx_reg, tx_next;
  reg_index_t idx_reg, idx_next;
  logic       ack_reg, ack_next;
  logic       drv_reg, drv_next;
  logic       sda_low_reg, sda_low_next;
  logic       sdo_reg, sdo_next;
  logic       first_reg, first_next;
  logic       read_reg, read_next;
  logic       load_reg, load_next;
  logic       push;
  logic       fifo_in_ready;
  data_byte_t rx_byte;

  assign rx_byte = {rx_reg[6:0], sda_s};

  always_comb begin
    st_next      = st_reg;
    after_next   = after_reg;
    bit_next     = bit_reg;
    rx_next      = rx_reg;
    tx_next      = load_reg ? i_rd_data : tx_reg;
    idx_next     = idx_reg;
    ack_next     = ack_reg;
    drv_next     = drv_reg;
    sda_low_next = sda_low_reg;
    sdo_next     = sdo_reg;
    first_next   = first_reg;
    read_next    = read_reg;
    load_next    = 1'b0;
    push         = 1'b0;
    if (!cs_s) begin
      // SPI owns the pins; two-wire side parked
      st_next      = ST_IDLE;
      sda_low_next = 1'b0;
      if (cs_fall) begin
        bit_next   = `SRA_BIT_FIRST;
        first_next = 1'b1;
      end else begin
        if (scl_rise) begin
          rx_next  = rx_byte;
          bit_next = bit_reg + `SRA_BIT_STEP;
          if (bit_reg == `SRA_BIT_LAST) begin
            first_next = 1'b0;
            if (first_reg) begin
              read_next = rx_byte[`SRA_RW_BIT];
              idx_next  = rx_byte[6:0];
              load_next = rx_byte[`SRA_RW_BIT];
            end else if (read_reg) begin
              idx_next  = idx_reg + `SRA_IDX_STEP;
              load_next = 1'b1;
            end else begin
              // A full FIFO drops SPI bytes: SPI has no way to stall
              push     = 1'b1;
              idx_next = idx_reg + `SRA_IDX_STEP;
            end
          end
        end
        if (scl_fall) begin
          sdo_next = tx_reg[7];
          tx_next  = {tx_reg[6:0], 1'b0};
        end
      end
    end else if (i_two_wire_port_disable) begin
      st_next      = ST_IDLE;
      sda_low_next = 1'b0;
    end else if (start_c) begin
      st_next      = ST_ADDR;
      bit_next     = `SRA_BIT_FIRST;
      sda_low_next = 1'b0;
    end else if (stop_c) begin
      st_next      = ST_IDLE;
      sda_low_next = 1'b0;
    end else if (scl_rise) begin
      unique case (st_reg)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          rx_next  = rx_byte;
          bit_next = bit_reg + `SRA_BIT_STEP;
          if (bit_reg == `SRA_BIT_LAST) begin
            st_next  = ST_ACK;
            drv_next = 1'b0;
            ack_next = 1'b1;
            if (st_reg == ST_ADDR) begin
              ack_next   = (rx_byte[7:1] == {`SRA_DEV_ADDR_HI, addr_s});
              read_next  = rx_byte[0];
              after_next = rx_byte[0] ? ST_TX : ST_INDEX;
              load_next  = rx_byte[0] &&
                           (rx_byte[7:1] == {`SRA_DEV_ADDR_HI, addr_s});
            end else if (st_reg == ST_INDEX) begin
              idx_next   = rx_byte[6:0];
              after_next = ST_WDATA;
            end else begin
              // Full FIFO answers with a not-acknowledge to stall the host
              ack_next   = fifo_in_ready;
              push       = fifo_in_ready;
              after_next = ST_WDATA;
              if (fifo_in_ready) begin
                idx_next = idx_reg + `SRA_IDX_STEP;
              end
            end
          end
        end
        ST_TX: begin
          bit_next = bit_reg + `SRA_BIT_STEP;
          if (bit_reg == `SRA_BIT_LAST) begin
            st_next  = ST_MACK;
            idx_next = idx_reg + `SRA_IDX_STEP;
          end
        end
        ST_MACK: begin
          bit_next = `SRA_BIT_FIRST;
          if (!sda_s) begin
            st_next   = ST_TX;
            load_next = 1'b1;
          end else begin
            st_next = ST_IDLE;
          end
        end
        ST_IDLE, ST_ACK: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (st_reg)
        ST_ACK: begin
          if (!drv_reg) begin
            drv_next     = 1'b1;
            sda_low_next = ack_reg;
            if (!ack_reg) begin
              st_next = ST_IDLE;
            end
          end else begin
            bit_next     = `SRA_BIT_FIRST;
            st_next      = after_reg;
            sda_low_next = 1'b0;
            if (after_reg == ST_TX) begin
              sda_low_next = !tx_reg[7];
              tx_next      = {tx_reg[6:0], 1'b0};
            end
          end
        end
        ST_TX: begin
          sda_low_next = !tx_reg[7];
          tx_next      = {tx_reg[6:0], 1'b0};
        end
        ST_MACK: begin
          sda_low_next = 1'b0;
        end
        ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_reg      <= ST_IDLE;
      after_reg   <= ST_IDLE;
      bit_reg     <= `SRA_BIT_FIRST;
      rx_reg      <= '0;
      tx_reg      <= '0;
      idx_reg     <= '0;
      ack_reg     <= 1'b0;
      drv_reg     <= 1'b0;
      sda_low_reg <= 1'b0;
      sdo_reg     <= 1'b0;
      first_reg   <= 1'b0;
      read_reg    <= 1'b0;
      load_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      after_reg   <= after_next;
      bit_reg     <= bit_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      idx_reg     <= idx_next;
      ack_reg     <= ack_next;
      drv_reg     <= drv_next;
      sda_low_reg <= sda_low_next;
      sdo_reg     <= sdo_next;
      first_reg   <= first_next;
      read_reg    <= read_next;
      load_reg    <= load_next;
    end
  end

  // --------------------------------------------------------------------
  // Pins and register side
  // --------------------------------------------------------------------
  // Open drain: only ever pulls low; clock and select are inputs only
  assign o_sda_o     = 1'b0;
  assign o_sda_oe_b  = !sda_low_reg;
  assign o_sdo       = sdo_reg;
  // Released two clocks after select rises, due to the synchroniser
  assign o_sdo_oe_b  = cs_s;
  assign o_rd_index  = idx_reg;
  assign o_rd_strobe = load_reg;

  sra_fifo #(
    .WIDTH (`SRA_FIFO_WIDTH),
    .DEPTH (`SRA_FIFO_DEPTH)
  ) sra_fifo_i (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({idx_reg, rx_byte}),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  ({o_wr_index, o_wr_data})
  );
endmodule // serial_register_access_slave

// [shared/sra_defs.svh]
// Constants for the serial register access slave (two-wire and SPI).
// Assumes the includer sits on the 20 MHz system clock domain.
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH

`define SRA_DEV_ADDR_HI  6'h34
`define SRA_BIT_LAST     3'h7
`define SRA_BIT_FIRST    3'h0
`define SRA_BIT_STEP     3'h1
`define SRA_IDX_STEP     7'h01
`define SRA_RW_BIT       7
`define SRA_FIFO_DEPTH   16
`define SRA_FIFO_WIDTH   15
`define SRA_SYNC_RST     4'hF

`endif

// [shared/sra_pkg.sv]
// Types shared by the serial register access slave.
// Assumes sra_defs.svh is included by the user of these types.
package sra_pkg;

  typedef logic [6:0] reg_index_t;
  typedef logic [7:0] data_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_WDATA,
    ST_ACK,
    ST_TX,
    ST_MACK
  } tw_state_e;

endpackage

// [verif/host.sv]
// Host master model driving select, clock and data of both ports.
// Assumes its tasks are entered at a falling i_clk edge.
`timescale 1ns/1ps
module host (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sda_o,
  input  wire logic i_sda_oe_b,
  output logic      o_cs_b,
  output logic      o_sclk,
  output logic      o_line
);
  // ----------------------------------------------------------------
  // Pins and tasks
  // ----------------------------------------------------------------
  logic sdi_reg = 1'b1;
  logic pull_reg = 1'b0;
  initial o_cs_b = 1'b1;
  initial o_sclk = 1'b1;
  // Pushed in SPI, else open drain with pull-up so a stale value never shows
  assign o_line = !o_cs_b ? sdi_reg
                : !(pull_reg || (!i_sda_oe_b && !i_sda_o));
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic spi_begin;
    o_cs_b = 1'b0;
    w(4);
  endtask
  task automatic spi_end;
    w(4);
    o_cs_b = 1'b1;
    w(8);
  endtask
  // 400 ns clock; bits read late in the high phase, the slave lags a fall
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sclk = 1'b0;
      sdi_reg = tx[i];
      w(4);
      o_sclk = 1'b1;
      w(4);
      rx[i] = i_sdo;
    end
  endtask
  // One 2.5 us clock: level a while low, level b from mid high
  task automatic tw_clk(input logic a, input logic b, output logic r);
    o_sclk = 1'b0;
    w(12);
    pull_reg = !a;
    w(13);
    o_sclk = 1'b1;
    w(12);
    r = o_line;
    pull_reg = !b;
    w(13);
  endtask
  task automatic tw_byte(input logic [7:0] tx, input logic ack_out,
                         output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) tw_clk(tx[i], tx[i], rx[i]);
    tw_clk(ack_out, ack_out, ack_in);
  endtask
endmodule // host

// [verif/serial_register_access_slave_bench.sv]
// Self-checking bench for the serial register access slave.
// Assumes host drives the pins; the register side is modelled here.
`timescale 1ns/1ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
  n_errors++; $display("wrong value at %0t: %s", $time, m); end end
module serial_register_access_slave_bench;
  import sra_pkg::*;
  // ----------------------------------------------------------------
  // Harness and scenarios
  // ----------------------------------------------------------------
  logic clk = 0, rst_b = 0, tw_off = 0, sel = 1, wr_ready = 0;
  logic cs_b, sclk, line, sda_o, sda_oe_b, sdo, sdo_oe_b, strobe, wr_valid;
  reg_index_t rd_index, wr_index;
  data_byte_t wr_data;
  int n_errors = 0, check_count = 0;
  function automatic data_byte_t rd_model(reg_index_t x);
    return {x[3:0], x[6:3]} ^ 8'h5A;
  endfunction
  always #25 clk = ~clk;
  // A released output shows the inverse, so a late enable cannot hide
  host host_i (.i_clk(clk), .i_sdo(sdo_oe_b ? !sdo : sdo), .i_sda_o(sda_o),
    .i_sda_oe_b(sda_oe_b), .o_cs_b(cs_b), .o_sclk(sclk), .o_line(line));
  serial_register_access_slave serial_register_access_slave_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_scl_sclk(sclk),
    .i_sda_sdi(line), .o_sda_o(sda_o), .o_sda_oe_b(sda_oe_b), .o_sdo(sdo),
    .o_sdo_oe_b(sdo_oe_b), .i_address_select_pin(sel),
    .i_two_wire_port_disable(tw_off), .o_rd_index(rd_index),
    .i_rd_data(rd_model(rd_index)), .o_rd_strobe(strobe),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_index(wr_index),
    .o_wr_data(wr_data));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Ready stays up; every word is seen at a falling edge before its pop
  task automatic drain(input logic [14:0] exp[$]);
    wr_ready = 1'b1;
    foreach (exp[k]) begin
      for (int t = 0; t < 20 && wr_valid !== 1'b1; t++) @(negedge clk);
      `CHK({wr_index, wr_data}, exp[k], "write word")
      @(negedge clk);
    end
    wr_ready = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(wr_valid, 1'b0, "fifo empty")
  endtask
  // Stalled register side: the seventeenth byte finds the buffer full
  task automatic t_spi_fill;
    logic [7:0] r;
    logic [14:0] q[$];
    logic [2:0] k;
    host_i.spi_begin();
    host_i.spi_byte(8'h10, r);
    for (int k = 0; k < 17; k++) begin
      host_i.spi_byte(8'hA5 ^ 8'(k), r);
      if (k < 16) q.push_back({7'h10 + 7'(k), 8'hA5 ^ 8'(k)});
    end
    host_i.spi_end();
    // Buffer still full: a two-wire data byte must be refused
    host_i.tw_clk(1'b1, 1'b0, r[0]);
    host_i.tw_byte(8'hD2, 1'b1, r, k[0]);
    host_i.tw_byte(8'h50, 1'b1, r, k[1]);
    host_i.tw_byte(8'h66, 1'b1, r, k[2]);
    host_i.tw_clk(1'b0, 1'b1, r[0]);
    `CHK(k, 3'b100, "full nack")
    drain(q);
    $display("spi fill done");
  endtask
  task automatic t_spi_read;
    logic [7:0] r, x, y;
    host_i.spi_begin();
    host_i.spi_byte(8'hA2, r);
    host_i.spi_byte(8'h00, x);
    host_i.spi_byte(8'h00, y);
    host_i.spi_end();
    `CHK(x, rd_model(7'h22), "spi read 1")
    `CHK(y, rd_model(7'h23), "spi read 2")
    `CHK({sdo_oe_b, wr_valid}, 2'b10, "spi idle")
    $display("spi read done");
  endtask
  task automatic t_tw_write;
    logic [7:0] r;
    logic [3:0] k;
    logic [14:0] q[$];
    host_i.tw_clk(1'b1, 1'b0, r[0]);
    host_i.tw_byte(8'hD2, 1'b1, r, k[0]);
    host_i.tw_byte(8'h30, 1'b1, r, k[1]);
    host_i.tw_byte(8'h11, 1'b1, r, k[2]);
    host_i.tw_byte(8'h22, 1'b1, r, k[3]);
    host_i.tw_clk(1'b0, 1'b1, r[0]);
    `CHK(k, 4'h0, "write acks")
    q.push_back({7'h30, 8'h11});
    q.push_back({7'h31, 8'h22});
    drain(q);
    $display("two-wire write done");
  endtask
  task automatic t_tw_read;
    logic [7:0] r, x, y;
    logic [4:0] k;
    host_i.tw_clk(1'b1, 1'b0, r[0]);
    host_i.tw_byte(8'hD2, 1'b1, r, k[0]);
    host_i.tw_byte(8'h40, 1'b1, r, k[1]);
    host_i.tw_clk(1'b1, 1'b0, r[0]);
    host_i.tw_byte(8'hD3, 1'b1, r, k[2]);
    host_i.tw_byte(8'hFF, 1'b0, x, k[3]);
    host_i.tw_byte(8'hFF, 1'b1, y, k[4]);
    host_i.tw_clk(1'b0, 1'b1, r[0]);
    `CHK(k, 5'b10000, "read acks")
    `CHK(x, rd_model(7'h40), "read byte 1")
    `CHK(y, rd_model(7'h41), "read byte 2")
    `CHK(sda_oe_b, 1'b1, "sda released")
    $display("two-wire read done");
  endtask
  task automatic t_tw_refuse;
    logic [7:0] r;
    logic [2:0] k;
    for (int i = 0; i < 3; i++) begin
      tw_off = (i == 1);
      sel = (i != 2);
      host_i.tw_clk(1'b1, 1'b0, r[0]);
      host_i.tw_byte(8'hD0 | {7'h00, i == 1}, 1'b1, r, k[i]);
      host_i.tw_clk(1'b0, 1'b1, r[0]);
    end
    tw_off = 1'b0;
    `CHK(k, 3'b011, "address match")
    $display("two-wire refuse done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({sda_oe_b, sdo_oe_b, wr_valid, strobe}, 4'b1100, "reset")
    t_spi_fill();
    t_spi_read();
    t_tw_write();
    t_tw_read();
    t_tw_refuse();
    conclude();
  end
  // Scenarios need about 0.44 ms; four times that means a hang
  initial begin
    #1_800_000;
    n_errors++;
    conclude();
  end
endmodule // serial_register_access_slave_bench

// [verif/serial_register_access_slave_props.sv]
// Checker for the serial register access slave, on its ports only.
// Assumes the bind below and the single i_clk domain.
`timescale 1ns/1ps
module sra_props (
  input wire logic                i_clk,
  input wire logic                i_rst_b,
  input wire logic                i_cs_b,
  input wire logic                i_scl_sclk,
  input wire logic                i_two_wire_port_disable,
  input wire logic                i_wr_ready,
  input wire logic                o_sdo,
  input wire logic                o_sdo_oe_b,
  input wire logic                o_sda_oe_b,
  input wire logic                o_rd_strobe,
  input wire logic                o_wr_valid,
  input wire sra_pkg::reg_index_t o_wr_index,
  input wire sra_pkg::data_byte_t o_wr_data
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_sdo_idle; i_cs_b [*3] |-> o_sdo_oe_b; endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo idle");
  property p_sdo_on; !i_cs_b [*4] |-> !o_sdo_oe_b; endproperty
  a_sdo_on: assert property (p_sdo_on) else $error("sdo on");
  property p_strobe; o_rd_strobe |=> !o_rd_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
  property p_hold;
    o_wr_valid && !i_wr_ready |=>
      o_wr_valid && $stable({o_wr_index, o_wr_data});
  endproperty
  a_hold: assert property (p_hold) else $error("fifo head");
  property p_park; i_two_wire_port_disable [*2] |-> o_sda_oe_b; endproperty
  a_park: assert property (p_park) else $error("parked");
  property p_spi_quiet; !i_cs_b [*4] |-> o_sda_oe_b; endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("sda");
  // Slave output may move only a few clocks after a clock fall
  property p_sdo_fall;
    !o_sdo_oe_b && !i_cs_b && !$past(i_cs_b, 6) && $changed(o_sdo)
      |-> !$past(i_scl_sclk, 2);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo edge");
  property p_strobe_rise; o_rd_strobe |-> $past(i_scl_sclk, 2); endproperty
  a_strobe_rise: assert property (p_strobe_rise) else $error("rise");
endmodule // sra_props
bind serial_register_access_slave sra_props sra_props_i (.i_clk, .i_rst_b,
  .i_cs_b, .i_scl_sclk, .i_two_wire_port_disable, .i_wr_ready, .o_sdo,
  .o_sdo_oe_b, .o_sda_oe_b, .o_rd_strobe, .o_wr_valid, .o_wr_index,
  .o_wr_data);
